//--- verilog/swc_sleep_ctrl.sv
// sleep entry, wake-up and watchdog control with apb registers
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"

// Overview of operation
// - crystal modes hold the watchdog cleared until the start-up timer ends.
// - watchdog clears on fuse off, clear instruction, osc fail, every wake.
// - sleep clears watchdog, clears powerdown flag, sets timeout flag, holds pins.
// - watchdog reset is internal and never pulls master clear low.
// - master clear resets; watchdog or interrupt wake resumes without reset.
// - powerdown flag set at power-up, cleared when sleep takes effect.
// - timeout flag cleared when the watchdog times out.
// - only the six asynchronous sources and a watchdog timeout can wake the device.
// - next instruction is prefetched as sleep executes and runs first on wake.
// - a source wakes only with its enable set, whatever the global enable.
// - global enable clear resumes in line; set runs one then vectors 0004h.
// - enabled and flagged source with global enable clear wakes at once.
// - watchdog is cleared at every wake-up.
// - pending enabled flag turns sleep into a no-operation, no flag change.
// - interrupt after the sleep cycle: sleep takes effect, wake immediately.
// - crystal modes wait 1024 oscillator periods on wake, others none.
// - four 7-bit id words reachable only in program/verify mode.
// - in program mode data and clock pins are the serial programming port.
// - memory readable when unprotected; removing protection erases memory.
// - watchdog timeout resets when running and wakes when asleep.
module swc_sleep_ctrl #(
  parameter int unsigned WDT_CYC = `SWC_WDT_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  input  wire swc_pkg::swc_core_t core,
  input  wire swc_pkg::swc_irq_t  irq,
  input  wire logic [7:0]       fuse_word,
  input  wire logic             master_clear_pin,
  input  wire logic             hv_detect,
  input  wire logic             prog_data_pin,
  input  wire logic             prog_clock_pin,
  output logic                  wdt_reset,
  output logic                  ext_reset,
  output logic                  osc_driver_off,
  output logic                  io_hold,
  output logic                  core_stall,
  output logic                  prefetch_next,
  output logic                  resume,
  output logic                  vector_req,
  output logic [12:0]           vector_addr,
  output logic                  prog_mode,
  output logic                  serial_data,
  output logic                  serial_clock,
  output logic                  mem_read_ok,
  output logic                  bulk_erase
);
  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // crystal-type oscillator modes need the start-up timer
  function automatic logic is_xtal(input logic [2:0] f);
    is_xtal = (f == `SWC_FOSC_LP) || (f == `SWC_FOSC_XT) ||
              (f == `SWC_FOSC_HS);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic       master_clear_pin_n_s;
  logic       hv_s;
  logic       pdat_s;
  logic       pclk_s;

  // two flops on every asynchronous pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 4'h1;
      pin_s2_q <= 4'h1;
    end else begin
      pin_s1_q <= {prog_clock_pin, prog_data_pin, hv_detect,
                   master_clear_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign master_clear_pin_n_s = pin_s2_q[0];
  assign hv_s     = pin_s2_q[1];
  assign pdat_s   = pin_s2_q[2];
  assign pclk_s   = pin_s2_q[3];

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  swc_pkg::swc_state_t state_q, state_d;
  logic [7:0]  opt_q;
  logic        pd_q, pd_d;
  logic        to_q, to_d;
  logic [31:0] wdt_q, wdt_d;
  logic [10:0] ost_q, ost_d;
  logic        gie_q, gie_d;
  logic        hv_q;
  logic        prog_q;
  logic        cp_q;
  logic        cp_seen_q;
  logic [`SWC_ID_BITS-1:0] id_q [4];
  logic [31:0] prdata_q;
  logic        perr_q;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  wire        watchdog_fuse_enable     = fuse_word[`SWC_CFG_WATCHDOG_FUSE_ENABLE];
  wire        xtal     = is_xtal(fuse_word[2:0]);
  wire        pending  = |(irq.flag & irq.en);
  wire        psa      = opt_q[`SWC_OPT_PSA];
  wire [31:0] wdt_lim  = psa ? (WDT_CYC << opt_q[2:0]) : WDT_CYC;
  wire        wdt_to   = watchdog_fuse_enable && (wdt_q >= wdt_lim - 32'h1);
  wire        sleep_ok = core.sleep_instr && !pending &&
                         (state_q == swc_pkg::SWC_RUN);
  wire        master_clear_pin_rst = !master_clear_pin_n_s && !hv_s;
  wire        setup    = psel && !penable;
  wire        acc_wr   = psel && penable && pwrite;
  wire        id_hit   = (paddr[11:4] == 8'(`SWC_ID_OFS >> 4));
  wire [1:0]  id_idx   = paddr[3:2];
  wire        id_ok    = id_hit && prog_q;
  wire        known    = (paddr == `SWC_OPT_OFS) ||
                         (paddr == `SWC_CFG_OFS) ||
                         (paddr == `SWC_STAT_OFS) || id_ok;

  // ----------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ost_d   = ost_q;
    gie_d   = gie_q;
    case (state_q)
      swc_pkg::SWC_RUN: begin
        if (sleep_ok) begin
          state_d = swc_pkg::SWC_SLEEP;
          gie_d   = core.global_irq_enable;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        gie_d = core.global_irq_enable;
        if (pending || wdt_to) begin
          if (xtal) begin
            state_d = swc_pkg::SWC_OST;
            ost_d   = 11'(`SWC_OST_CYC - 1);
          end else begin
            state_d = swc_pkg::SWC_WAKE;
          end
        end
      end
      swc_pkg::SWC_OST: begin
        if (ost_q == 11'h0)
          state_d = swc_pkg::SWC_WAKE;
        else
          ost_d = ost_q - 11'h1;
      end
      swc_pkg::SWC_WAKE: state_d = swc_pkg::SWC_RUN;
      default: state_d = swc_pkg::SWC_RUN;
    endcase
    if (master_clear_pin_rst)
      state_d = swc_pkg::SWC_RUN;
  end

  // ----------------------------------------------------------------
  // watchdog counter and status flags
  // ----------------------------------------------------------------
  always_comb begin
    wdt_d = wdt_q + 32'h1;
    pd_d  = pd_q;
    to_d  = to_q;
    if (!watchdog_fuse_enable || core.clear_instr || core.osc_fail ||
        master_clear_pin_rst)
      wdt_d = 32'h0;
    if (sleep_ok) begin
      wdt_d = 32'h0;
      pd_d  = 1'b0;
      to_d  = 1'b1;
    end
    if (state_q == swc_pkg::SWC_OST ||
        state_q == swc_pkg::SWC_WAKE)
      wdt_d = 32'h0;
    if (state_q == swc_pkg::SWC_SLEEP && state_d != state_q)
      wdt_d = 32'h0;
    if (wdt_to && !sleep_ok) begin
      to_d  = 1'b0;
      wdt_d = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= swc_pkg::SWC_RUN;
      ost_q   <= 11'h0;
      gie_q   <= 1'b0;
      wdt_q   <= 32'h0;
      pd_q    <= 1'b1;
      to_q    <= 1'b1;
    end else begin
      state_q <= state_d;
      ost_q   <= ost_d;
      gie_q   <= gie_d;
      wdt_q   <= wdt_d;
      pd_q    <= pd_d;
      to_q    <= to_d;
    end
  end

  // ----------------------------------------------------------------
  // core-facing outputs
  // ----------------------------------------------------------------
  wire asleep = (state_q != swc_pkg::SWC_RUN);
  assign wdt_reset      = wdt_to && (state_q == swc_pkg::SWC_RUN);
  assign ext_reset      = master_clear_pin_rst;
  assign osc_driver_off = (state_q == swc_pkg::SWC_SLEEP);
  assign io_hold        = asleep;
  assign core_stall     = asleep;
  assign prefetch_next  = sleep_ok;
  assign resume         = (state_q == swc_pkg::SWC_WAKE);
  assign vector_req     = resume && gie_q;
  assign vector_addr    = `SWC_VECTOR;

  // ----------------------------------------------------------------
  // program/verify mode and code protection
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_q      <= 1'b0;
      prog_q    <= 1'b0;
      cp_q      <= 1'b0;
      cp_seen_q <= 1'b0;
    end else begin
      hv_q      <= hv_s;
      cp_q      <= fuse_word[`SWC_CFG_CP];
      cp_seen_q <= 1'b1;
      if (!hv_s)
        prog_q <= 1'b0;
      else if (!hv_q && !pdat_s && !pclk_s)
        prog_q <= 1'b1;
    end
  end

  assign prog_mode    = prog_q;
  assign serial_data  = prog_q && pdat_s;
  assign serial_clock = prog_q && pclk_s;
  assign mem_read_ok  = prog_q && fuse_word[`SWC_CFG_CP];
  assign bulk_erase   = cp_seen_q && !cp_q &&
                        fuse_word[`SWC_CFG_CP];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // read data and error captured in setup, shown in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      perr_q   <= 1'b0;
    end else if (setup) begin
      perr_q   <= !known;
      prdata_q <= 32'h0;
      if (paddr == `SWC_OPT_OFS)
        prdata_q <= {24'h0, opt_q};
      else if (paddr == `SWC_CFG_OFS)
        prdata_q <= {24'h0, fuse_word};
      else if (paddr == `SWC_STAT_OFS)
        prdata_q <= {28'h0, prog_q, asleep, to_q, pd_q};
      else if (id_ok)
        prdata_q <= {25'h0, id_q[id_idx]};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && perr_q;
  assign prdata  = prdata_q;

  // option register and id words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= `SWC_OPT_RST;
      for (int i = 0; i < 4; i++)
        id_q[i] <= 7'h0;
    end else if (acc_wr) begin
      if (paddr == `SWC_OPT_OFS)
        opt_q <= pwdata[7:0];
      if (id_ok)
        id_q[id_idx] <= pwdata[`SWC_ID_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sleep_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    sleep_ok |=> !pd_q && to_q && wdt_q == 32'h0)
    else $error("sleep entry flags wrong");

  a_nop_sleep: assert property (
    @(posedge pclk) disable iff (!presetn)
    core.sleep_instr && pending && state_q == swc_pkg::SWC_RUN
    |=> state_q == swc_pkg::SWC_RUN && $stable(pd_q))
    else $error("sleep not a no-op with pending irq");

  a_wake_now: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == swc_pkg::SWC_SLEEP && pending && !xtal && !master_clear_pin_rst
    |=> resume)
    else $error("no immediate wake");

  a_ost_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == swc_pkg::SWC_OST |=> wdt_q == 32'h0)
    else $error("watchdog ran during start-up");

  // cycles spent in the start-up wait, read by the length check
  logic [10:0] ost_run_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ost_run_q <= 11'h0;
    else if (state_q == swc_pkg::SWC_OST)
      ost_run_q <= ost_run_q + 11'h1;
    else
      ost_run_q <= 11'h0;
  end

  a_ost_enter: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == swc_pkg::SWC_SLEEP && (pending || wdt_to) && xtal &&
    !master_clear_pin_rst |=> state_q == swc_pkg::SWC_OST && !resume)
    else $error("crystal wake skipped start-up wait");

  a_ost_len: assert property (
    @(posedge pclk) disable iff (!presetn || master_clear_pin_rst)
    resume && $past(state_q) == swc_pkg::SWC_OST
    |-> ost_run_q == 11'(`SWC_OST_CYC))
    else $error("start-up wait not 1024 cycles");

  a_wake_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == swc_pkg::SWC_SLEEP && (pending || wdt_to)
    |=> wdt_q == 32'h0)
    else $error("watchdog not cleared on wake");

  a_wdt_run_rst: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdt_to && !asleep |-> wdt_reset ##1 !to_q)
    else $error("run timeout did not reset");

  a_wdt_fuse_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !watchdog_fuse_enable |=> wdt_q == 32'h0)
    else $error("disabled watchdog counted");

  a_vector: assert property (
    @(posedge pclk) disable iff (!presetn)
    resume |-> vector_req == gie_q ##1 !vector_req && !io_hold)
    else $error("vector request mismatch");

  a_id_lock: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && id_hit && !prog_q |=> pslverr && prdata == 32'h0)
    else $error("id word reachable outside program mode");
endmodule
`default_nettype wire

//--- common/swc_regs.svh
// register map, field positions and timing counts of the sleep controller
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SWC_OPT_OFS   12'h000
`define SWC_CFG_OFS   12'h004
`define SWC_STAT_OFS  12'h008
`define SWC_ID_OFS    12'h010
`define SWC_OPT_RST   8'hFF
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SWC_OPT_PSA   3
`define SWC_CFG_CP    6
`define SWC_CFG_WATCHDOG_FUSE_ENABLE  3
`define SWC_ST_PD     0
`define SWC_ST_TO     1
`define SWC_ST_SLEEP  2
`define SWC_ST_PROG   3
`define SWC_ID_BITS   7
`define SWC_FOSC_LP   3'h0
`define SWC_FOSC_XT   3'h1
`define SWC_FOSC_HS   3'h2
`define SWC_VECTOR    13'h0004
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWC_CLK_NS    5
`define SWC_WDT_MS    18
`define SWC_WDT_CYC   (`SWC_WDT_MS * 1000000 / `SWC_CLK_NS)
`define SWC_OST_TOSC  1024
`define SWC_OST_CYC   `SWC_OST_TOSC
`endif

//--- common/swc_pkg.sv
// types shared by the sleep and wake-up controller
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_OST,
    SWC_WAKE
  } swc_state_t;
  // wake-capable interrupt sources: tmr1, capture, adc, cmp, ioc, ext
  typedef struct packed {
    logic [5:0] flag;
    logic [5:0] en;
  } swc_irq_t;
  typedef struct packed {
    logic       sleep_instr;
    logic       clear_instr;
    logic       osc_fail;
    logic       global_irq_enable;
  } swc_core_t;
endpackage

//--- verification/swc_core_model.sv
// processor core and wake source model beside the sleep controller
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
  input  wire logic              pclk,
  output var swc_pkg::swc_core_t core,
  output var swc_pkg::swc_irq_t  irq
);
  initial begin
    core = '0;
    irq  = '0;
  end
  // instruction strobes last exactly one cycle
  always @(posedge pclk) begin
    if (core.clear_instr) core.clear_instr <= 1'b0;
    if (core.sleep_instr) core.sleep_instr <= 1'b0;
    if (core.osc_fail)    core.osc_fail    <= 1'b0;
  end
  // software habit: kick the watchdog, then sleep on the next cycle
  task sleep_req(input logic g);
    @(posedge pclk);
    core.clear_instr <= 1'b1;
    core.global_irq_enable         <= g;
    @(posedge pclk);
    core.sleep_instr <= 1'b1;
  endtask
  // watchdog kick alone, by clear instruction or oscillator fail
  task clear_req(input logic fail);
    @(posedge pclk);
    if (fail)
      core.osc_fail <= 1'b1;
    else
      core.clear_instr <= 1'b1;
  endtask
  // flag and enable levels of the six wake sources
  task set_irq(input logic [5:0] f, input logic [5:0] e);
    @(posedge pclk);
    irq.flag <= f;
    irq.en   <= e;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
module tb_top;
  localparam int DOG = 64;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, r;
  swc_pkg::swc_core_t core;
  swc_pkg::swc_irq_t  irq;
  logic [7:0]         fuse_word;
  logic               master_clear_pin, hv_detect, prog_data_pin;
  logic               prog_clock_pin, wdt_reset, ext_reset, osc_driver_off;
  logic               io_hold, core_stall, prefetch_next, resume, e;
  logic               vector_req, prog_mode, serial_data, serial_clock;
  logic               mem_read_ok, bulk_erase;
  logic [12:0]        vector_addr;
  int                 failures, checks_done, cycles, n;

  swc_sleep_ctrl #(.WDT_CYC(DOG)) swc_sleep_ctrl_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .core, .irq, .fuse_word, .master_clear_pin, .hv_detect, .prog_data_pin,
    .prog_clock_pin, .wdt_reset, .ext_reset, .osc_driver_off, .io_hold,
    .core_stall, .prefetch_next, .resume, .vector_req, .vector_addr,
    .prog_mode, .serial_data, .serial_clock, .mem_read_ok, .bulk_erase);
  swc_core_model swc_core_model_inst (.pclk, .core, .irq);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(string nm, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, g);
      failures++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(logic w, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
           output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(string nm, logic [11:0] a, logic [31:0] x, logic xe);
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk({nm, "_err"}, {31'h0, xe}, {31'h0, e});
  endtask
  // edges until resume (0), wdt_reset (1) or bulk_erase (2) shows
  task wait_on(int w, int lim, output int k);
    k = 0;
    while (k < lim && !(w == 0 ? resume === 1'b1 :
           w == 1 ? wdt_reset === 1'b1 : bulk_erase === 1'b1)) begin
      @(posedge pclk);
      #1 k++;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs();
    rd_chk("option", `SWC_OPT_OFS, 32'h0000_00FF, 1'b0);
    rd_chk("status", `SWC_STAT_OFS, 32'h0000_0003, 1'b0);
    apb(1'b1, `SWC_CFG_OFS, 32'h0000_0000, r, e);
    rd_chk("fuse", `SWC_CFG_OFS, 32'h0000_000C, 1'b0);
    rd_chk("unmapped", 12'h0F0, 32'h0, 1'b1);
    rd_chk("id_locked", `SWC_ID_OFS, 32'h0, 1'b1);
  endtask
  task t_nop();
    swc_core_model_inst.set_irq(6'h10, 6'h10);
    swc_core_model_inst.sleep_req(1'b0);
    repeat (3) @(posedge pclk);
    #1 chk("nop_sleep", 32'h0, {31'h0, osc_driver_off});
    rd_chk("nop_status", `SWC_STAT_OFS, 32'h3, 1'b0);
    swc_core_model_inst.set_irq(6'h0, 6'h0);
  endtask
  task t_wake(logic g, logic [5:0] s);
    swc_core_model_inst.set_irq(~s, s);
    swc_core_model_inst.sleep_req(g);
    #1 chk("prefetch", 32'h1, {31'h0, prefetch_next});
    @(posedge pclk);
    #1 chk("asleep", 32'h3, {30'h0, osc_driver_off, io_hold});
    chk("stall", 32'h1, {31'h0, core_stall});
    rd_chk("sleep_status", `SWC_STAT_OFS, 32'h6, 1'b0);
    repeat (8) @(posedge pclk);
    #1 chk("masked_src", 32'h1, {31'h0, osc_driver_off});
    swc_core_model_inst.set_irq(6'h3F, s);
    #1 wait_on(0, 3, n);
    chk("fast_wake", 32'h1, {31'h0, resume === 1'b1});
    chk("vector_req", {31'h0, g}, {31'h0, vector_req});
    chk("vector_addr", 32'h4, {19'h0, vector_addr});
    swc_core_model_inst.set_irq(6'h0, 6'h0);
    rd_chk("wake_status", `SWC_STAT_OFS, 32'h2, 1'b0);
  endtask
  task t_dog();
    apb(1'b1, `SWC_OPT_OFS, 32'h0, r, e);
    swc_core_model_inst.clear_req(1'b1);
    #1 wait_on(1, 200, n);
    chk("run_tmo", 32'h1, {31'h0, n >= DOG-4 && n <= DOG+4});
    chk("ext_rst_low", 32'h0, {31'h0, ext_reset});
    rd_chk("tmo_status", `SWC_STAT_OFS, 32'h0, 1'b0);
    swc_core_model_inst.sleep_req(1'b0);
    #1 wait_on(0, 200, n);
    chk("dog_wake", 32'h1, {31'h0, resume === 1'b1 && n >= DOG-4});
    rd_chk("dog_status", `SWC_STAT_OFS, 32'h0, 1'b0);
    #1 wait_on(1, 200, n);
    chk("wake_clear", 32'h1, {31'h0, n >= DOG-12 && n <= DOG+4});
    apb(1'b1, `SWC_OPT_OFS, 32'hFF, r, e);
  endtask
  task t_xtal();
    @(posedge pclk) fuse_word <= 8'h09;
    swc_core_model_inst.sleep_req(1'b0);
    repeat (4) @(posedge pclk);
    swc_core_model_inst.set_irq(6'h02, 6'h02);
    #1 wait_on(0, 1100, n);
    chk("xtal_wait", 32'h1, {31'h0, n >= 1024 && n <= 1030});
    swc_core_model_inst.set_irq(6'h0, 6'h0);
    @(posedge pclk) fuse_word <= 8'h0C;
  endtask
  task t_prog();
    @(posedge pclk) hv_detect <= 1'b1;
    repeat (5) @(posedge pclk);
    #1 chk("prog_mode", 32'h1, {31'h0, prog_mode});
    @(posedge pclk) {prog_data_pin, prog_clock_pin} <= 2'b11;
    repeat (4) @(posedge pclk);
    #1 chk("serial", 32'h3, {30'h0, serial_data, serial_clock});
    apb(1'b1, `SWC_ID_OFS + 12'h4, 32'hFF, r, e);
    rd_chk("id_word", `SWC_ID_OFS + 12'h4, 32'h7F, 1'b0);
    rd_chk("id_last", `SWC_ID_OFS + 12'hC, 32'h0, 1'b0);
    @(posedge pclk) fuse_word <= 8'h4C;
    #1 wait_on(2, 6, n);
    chk("erase", 32'h1, {31'h0, bulk_erase});
    chk("readable", 32'h1, {31'h0, mem_read_ok});
    @(posedge pclk) {prog_data_pin, prog_clock_pin, hv_detect} <= 3'b0;
    repeat (5) @(posedge pclk);
    #1 chk("prog_left", 32'h0, {31'h0, prog_mode});
    rd_chk("id_closed", `SWC_ID_OFS + 12'h4, 32'h0, 1'b1);
  endtask
  // master clear dropped while asleep gives an external reset
  task t_master_clear_pin();
    swc_core_model_inst.sleep_req(1'b0);
    @(posedge pclk) master_clear_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 chk("master_clear_pin_reset", 32'h2, {30'h0, ext_reset, osc_driver_off});
    rd_chk("master_clear_pin_status", `SWC_STAT_OFS, 32'h2, 1'b0);
    @(posedge pclk) master_clear_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk("master_clear_pin_release", 32'h0, {31'h0, ext_reset});
  endtask

  initial begin
    {presetn, psel, penable, pwrite, hv_detect} = 5'h0;
    {prog_data_pin, prog_clock_pin} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    fuse_word = 8'h0C;
    master_clear_pin = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_nop();
    for (int i = 0; i < 6; i++) t_wake(i[0], 6'h01 << i);
    t_dog();
    t_xtal();
    t_prog();
    t_master_clear_pin();
    summarize();
  end
endmodule
`default_nettype wire
